// ===== core/tccu_map.svh
/*
 Register offsets, field positions, reset values and prescaler terminal counts of the
 timer capture/compare unit.
 Assumes it is included by bare name wherever the map is needed.
*/
// Overview of operation
// - Two-bit timebase select; code 11 is reserved
// - Capture copies the 16-bit timer into holding
// - Capture event: fall, rise, 4th or 16th rise
// - Capture sets request flag; only software clears it
// - New capture overwrites unread holding value
// - Port write on output pin counts as event
// - Prescaler cleared when off, not capture, reset
// - Prescaler switch keeps count; write zero first
// - Timer holds in sleep unless externally clocked
// - Compare match runs mode action and sets flag
// - Mode 1010 only flags; pin stays port-owned
// - Writing zero to control clears compare latch
// - Mode 1011 resets timer, starts conversion
// - Trigger at match; timer clears next tick
// - Match removed before tick cancels timer reset
// - Conversion start exists on one unit only
// - Compare need not work while sleeping
// - Codes 0100-0111 select the four capture events
// - 0010 toggles, 1000 sets, 1001 clears on match
// - 0000 turns unit off; 0001, 0011 reserved
`ifndef TCCU_MAP_SVH
`define TCCU_MAP_SVH

// Byte offsets on the register bus
`define TCCU_OFS_CONTROL   5'h00
`define TCCU_OFS_HOLD_LOW  5'h04
`define TCCU_OFS_HOLD_HIGH 5'h08
`define TCCU_OFS_TIMEBASE  5'h0c
`define TCCU_OFS_STATUS    5'h10

// Field positions
`define TCCU_MODE_MSB      3
`define TCCU_MODE_LSB      0
`define TCCU_TB_MSB        1
`define TCCU_TB_LSB        0
`define TCCU_FLAG_BIT      0

// Reset values and reserved codes
`define TCCU_CONTROL_RST   8'h00
`define TCCU_HOLD_RST      8'h00
`define TCCU_TIMEBASE_RST  2'h0
`define TCCU_TIMEBASE_RSVD 2'h3

// Capture prescaler terminal counts
`define TCCU_PRE_EVERY1    4'h0
`define TCCU_PRE_EVERY4    4'h3
`define TCCU_PRE_EVERY16   4'hf

`endif

// ===== core/tccu_pkg.sv
/*
 Types of the timer capture/compare unit: mode codes and data widths.
 Assumes nothing of its surroundings.
*/
package tccu_pkg;
   // Unit mode field codes
   typedef enum logic [3:0] {
      TCCU_OFF        = 4'b0000,
      TCCU_RSVD1      = 4'b0001,
      TCCU_CMP_TOGGLE = 4'b0010,
      TCCU_RSVD3      = 4'b0011,
      TCCU_CAP_FALL   = 4'b0100,
      TCCU_CAP_RISE   = 4'b0101,
      TCCU_CAP_RISE4  = 4'b0110,
      TCCU_CAP_RISE16 = 4'b0111,
      TCCU_CMP_SET    = 4'b1000,
      TCCU_CMP_CLEAR  = 4'b1001,
      TCCU_CMP_SOFT   = 4'b1010,
      TCCU_CMP_TRIG   = 4'b1011,
      TCCU_WAVE0      = 4'b1100,
      TCCU_WAVE1      = 4'b1101,
      TCCU_WAVE2      = 4'b1110,
      TCCU_WAVE3      = 4'b1111
   } tccu_mode_t;

   typedef logic [15:0] tccu_count_t;   // Timer and holding width
   typedef logic [1:0]  tccu_tbsel_t;   // Timebase select code
endpackage : tccu_pkg

// ===== core/tccu_top.sv
/*
 Timer capture/compare unit: capture of the 16-bit timer on pin events,
 compare against the timer with pin actions and a special trigger, and
 an Avalon-MM register slave with waitrequest.
 Assumes the 16-bit timer lives outside, presents its count synchronous
 to sys_clk and marks each of its own clock edges with a one-cycle tick.
*/
// Implementation choices: register access over Avalon-MM and the register addresses.
`timescale 1ns/10ps
`include "tccu_map.svh"

module tccu_top #(
   parameter bit HAS_CONV_START = 1'b1   // Conversion start fitted on this unit
) (
   input  wire logic                  sys_clk,          // 200 MHz system clock
   input  wire logic                  reset,            // Synchronous, active high
   // Avalon-MM slave
   input  wire logic [4:0]            address,          // Byte address
   input  wire logic                  read,             // Read request
   input  wire logic                  write,            // Write request
   input  wire logic [31:0]           writedata,        // Write data
   input  wire logic [3:0]            byteenable,       // Byte lanes
   output logic      [31:0]           readdata,         // Read data
   output logic                       waitrequest,      // Stall
   // 16-bit timer
   input  wire tccu_pkg::tccu_count_t timerCount,       // Timer count value
   input  wire logic                  timerTick,        // Timer clock edge marker
   input  wire logic                  timerExtClock,    // Timer clocked externally
   output logic                       timerClearReq,    // Clear timer at next tick
   output logic                       timerHold,        // Timer must hold its count
   // Pin and port
   input  wire logic                  unitPinIn,        // Pin level
   input  wire logic                  portLatch,        // Port output data latch
   input  wire logic                  pinDirection,     // 1 = input, 0 = output
   output logic                       unitPinOut,       // Compare output level
   output logic                       unitPinOeN,       // Low while unit drives pin
   // System
   input  wire logic                  sleepMode,        // Device asleep
   input  wire logic                  converterEnable,  // Converter enabled
   output logic                       specialTrigger,   // Special trigger pulse
   output logic                       conversionStart,  // Conversion start pulse
   output logic                       unitRequestFlag,  // Request flag level
   output tccu_pkg::tccu_tbsel_t      timebaseSel       // Waveform timebase code
);
   import tccu_pkg::*;

   // Decoders shared by several processes
   // Reserved and waveform codes fall through
   // every decoder and leave the unit idle

   // Mode is one of the capture codes
   function automatic logic isCapture(input logic [3:0] m);
      isCapture = (m[3:2] == 2'b01);
   endfunction : isCapture

   // Mode is one of the compare codes
   function automatic logic isCompare(input logic [3:0] m);
      isCompare = (m == TCCU_CMP_TOGGLE) || (m[3:2] == 2'b10);
   endfunction : isCompare

   // Compare mode that takes the pin
   function automatic logic drivesPin(input logic [3:0] m);
      drivesPin = (m == TCCU_CMP_TOGGLE) || (m == TCCU_CMP_SET) ||
                  (m == TCCU_CMP_CLEAR);
   endfunction : drivesPin

   logic [7:0]  control_q;       // Unit control register
   logic [7:0]  holdLow_q;       // Holding low byte
   logic [7:0]  holdHigh_q;      // Holding high byte
   tccu_tbsel_t timebase_q;      // Timebase select field
   logic        flag_q;          // Request flag
   logic        wait_q;          // Waitrequest register
   logic [31:0] rdata_q;         // Read data register
   logic [3:0]  preCount_q;      // Capture prescaler count
   logic        pinPrev_q;       // Pin level at previous tick
   logic        match_q;         // Match seen last cycle
   logic        cmpOut_q;        // Compare output latch
   logic        oeN_q;           // Pin enable, active low
   logic        clrReq_q;        // Timer clear pending
   logic        trig_q;          // Special trigger pulse
   logic        conv_q;          // Conversion start pulse
   logic        hold_q;          // Timer hold level

   tccu_mode_t  mode;            // Current mode
   logic        accept;          // Bus access completes this edge
   logic        wrCtl;           // Control write completes
   logic        wrLow;           // Low byte write completes
   logic        wrHigh;          // High byte write completes
   logic        wrTb;            // Timebase write completes
   logic        wrStat;          // Status write completes
   logic [3:0]  newMode;         // Mode being written
   logic        pinLevel;        // Effective pin level
   logic        pinRise;         // Rising edge at tick
   logic        pinFall;         // Falling edge at tick
   logic        edgeHit;         // Edge of the selected kind
   logic [3:0]  preLimit;        // Terminal count of prescaler
   logic        capHit;          // Capture taken this cycle
   logic        match;           // Holding equals timer
   logic        cmpHit;          // Compare event this cycle
   tccu_count_t holding;         // Holding pair

   assign mode    = tccu_mode_t'(control_q[`TCCU_MODE_MSB:`TCCU_MODE_LSB]);
   assign holding = {holdHigh_q, holdLow_q};
   assign newMode = writedata[`TCCU_MODE_MSB:`TCCU_MODE_LSB];

   // Accesses complete at the edge where waitrequest is sampled low
   assign accept = (read || write) && !wait_q;
   assign wrCtl  = write && !wait_q && byteenable[0] && (address == `TCCU_OFS_CONTROL);
   assign wrLow  = write && !wait_q && byteenable[0] && (address == `TCCU_OFS_HOLD_LOW);
   assign wrHigh = write && !wait_q && byteenable[0] && (address == `TCCU_OFS_HOLD_HIGH);
   assign wrTb   = write && !wait_q && byteenable[0] && (address == `TCCU_OFS_TIMEBASE);
   assign wrStat = write && !wait_q && byteenable[0] && (address == `TCCU_OFS_STATUS);

   // Port write shows on the pin when it is an output
   assign pinLevel = pinDirection ? unitPinIn : portLatch;
   assign pinRise  = timerTick && pinLevel && !pinPrev_q;
   assign pinFall  = timerTick && !pinLevel && pinPrev_q;

   // Event selection per capture code
   always_comb begin
      edgeHit  = 1'b0;
      preLimit = `TCCU_PRE_EVERY1;
      unique case (mode)
         TCCU_CAP_FALL:   edgeHit = pinFall;
         TCCU_CAP_RISE:   edgeHit = pinRise;
         TCCU_CAP_RISE4: begin
            edgeHit  = pinRise;
            preLimit = `TCCU_PRE_EVERY4;
         end
         TCCU_CAP_RISE16: begin
            edgeHit  = pinRise;
            preLimit = `TCCU_PRE_EVERY16;
         end
         default: edgeHit = 1'b0;
      endcase
   end

   // A count left high by a direct switch fires early
   assign capHit = edgeHit && (preCount_q >= preLimit);

   // Compare is live in compare modes while the clock runs
   assign match  = isCompare(mode) && (holding == timerCount) && !sleepMode;
   assign cmpHit = match && !match_q;

   // Bus handshake: one wait cycle, then completion
   // Idle waitrequest is high, so no access
   // completes without its wait cycle
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         wait_q <= 1'b1;
      end else begin
         wait_q <= !((read || write) && wait_q);
      end
   end

   // Read data prepared while waitrequest is still high
   // Unmapped offsets read as zero
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         rdata_q <= 32'h0;
      end else if (read && wait_q) begin
         unique case (address)
            `TCCU_OFS_CONTROL:   rdata_q <= {24'h0, control_q};
            `TCCU_OFS_HOLD_LOW:  rdata_q <= {24'h0, holdLow_q};
            `TCCU_OFS_HOLD_HIGH: rdata_q <= {24'h0, holdHigh_q};
            `TCCU_OFS_TIMEBASE:  rdata_q <= {30'h0, timebase_q};
            `TCCU_OFS_STATUS:    rdata_q <= {31'h0, flag_q};
            default:             rdata_q <= 32'h0;
         endcase
      end else if (accept) begin
         rdata_q <= 32'h0;
      end
   end

   // Control register; zero turns the unit off
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         control_q <= `TCCU_CONTROL_RST;
      end else if (wrCtl) begin
         control_q <= writedata[7:0];
      end
   end

   // Timebase select; the reserved code is not stored
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         timebase_q <= `TCCU_TIMEBASE_RST;
      end else if (wrTb && (writedata[`TCCU_TB_MSB:`TCCU_TB_LSB] != `TCCU_TIMEBASE_RSVD)) begin
         timebase_q <= writedata[`TCCU_TB_MSB:`TCCU_TB_LSB];
      end
   end

   // Holding pair: capture overwrites, software may write
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         holdLow_q  <= `TCCU_HOLD_RST;
         holdHigh_q <= `TCCU_HOLD_RST;
      end else if (capHit) begin
         holdLow_q  <= timerCount[7:0];
         holdHigh_q <= timerCount[15:8];
      end else begin
         if (wrLow) begin
            holdLow_q <= writedata[7:0];
         end
         if (wrHigh) begin
            holdHigh_q <= writedata[7:0];
         end
      end
   end

   // Request flag: hardware sets, write one clears, set wins
   // An event beside a clear keeps the flag
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         flag_q <= 1'b0;
      end else if (capHit || cmpHit) begin
         flag_q <= 1'b1;
      end else if (wrStat && writedata[`TCCU_FLAG_BIT]) begin
         flag_q <= 1'b0;
      end
   end

   // Prescaler: cleared outside capture, kept across capture codes
   // Switch codes via zero to avoid an early capture
   always_ff @(posedge sys_clk) begin
      if (reset || !isCapture(mode)) begin
         preCount_q <= 4'h0;
      end else if (capHit) begin
         preCount_q <= 4'h0;
      end else if (edgeHit) begin
         preCount_q <= preCount_q + 4'h1;
      end
   end

   // Pin level as seen at the last timer tick
   // Pulses shorter than a tick can be missed
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         pinPrev_q <= 1'b0;
      end else if (timerTick) begin
         pinPrev_q <= pinLevel;
      end
   end

   // Match history for single compare events
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         match_q <= 1'b0;
      end else begin
         match_q <= match;
      end
   end

   // Compare output latch: setup on mode write, action on match
   // Separate from the port data latch
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         cmpOut_q <= 1'b0;
      end else if (wrCtl) begin
         if (writedata[7:0] == 8'h00) begin
            cmpOut_q <= 1'b0;
         end else if (newMode == TCCU_CMP_SET) begin
            cmpOut_q <= 1'b0;
         end else if (newMode == TCCU_CMP_CLEAR) begin
            cmpOut_q <= 1'b1;
         end
      end else if (cmpHit) begin
         unique case (mode)
            TCCU_CMP_TOGGLE: cmpOut_q <= !cmpOut_q;
            TCCU_CMP_SET:    cmpOut_q <= 1'b1;
            TCCU_CMP_CLEAR:  cmpOut_q <= 1'b0;
            default:         cmpOut_q <= cmpOut_q;
         endcase
      end
   end

   // Unit owns the pin only in driving compare codes
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         oeN_q <= 1'b1;
      end else begin
         oeN_q <= !drivesPin(mode);
      end
   end

   // Special trigger pulse in the cycle after the first cycle of a match
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         trig_q <= 1'b0;
      end else begin
         trig_q <= cmpHit && (mode == TCCU_CMP_TRIG);
      end
   end

   // Conversion start, only where fitted and enabled
   // Units without the link keep it at zero
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         conv_q <= 1'b0;
      end else begin
         conv_q <= HAS_CONV_START && converterEnable &&
                   cmpHit && (mode == TCCU_CMP_TRIG);
      end
   end

   // Timer clear waits for the next tick and needs the match to last
   // Moving the holding pair off the match
   // before the tick cancels the clear
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         clrReq_q <= 1'b0;
      end else if (cmpHit && (mode == TCCU_CMP_TRIG)) begin
         clrReq_q <= 1'b1;
      end else if (timerTick || !match || (mode != TCCU_CMP_TRIG)) begin
         clrReq_q <= 1'b0;
      end
   end

   // Timer holds in sleep unless it runs from its external clock
   // Capture keeps working on an external clock
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         hold_q <= 1'b0;
      end else begin
         hold_q <= sleepMode && !timerExtClock;
      end
   end

   // Outputs straight from registers
   // No output path is combinational
   assign readdata        = rdata_q;
   assign waitrequest     = wait_q;
   assign timerClearReq   = clrReq_q;
   assign timerHold       = hold_q;
   assign unitPinOut      = cmpOut_q;
   assign unitPinOeN      = oeN_q;
   assign specialTrigger  = trig_q;
   assign conversionStart = conv_q;
   assign unitRequestFlag = flag_q;
   assign timebaseSel     = timebase_q;

endmodule : tccu_top

// ===== verif/tccu_monitor.sv
/* Port checker of the capture/compare unit.
   Assumes it is bound to tccu_top and sees only that module's ports. */
`timescale 1ns/10ps
`include "tccu_map.svh"
module tccu_monitor (
   input wire logic                  sys_clk,          // System clock
   input wire logic                  reset,            // Synchronous, active high
   input wire logic [4:0]            address,          // Bus address
   input wire logic                  read,             // Bus read
   input wire logic                  write,            // Bus write
   input wire logic [31:0]           readdata,         // Bus read data
   input wire logic                  waitrequest,      // Bus stall
   input wire logic                  timerTick,        // Timer tick marker
   input wire logic                  timerExtClock,    // External timer clock
   input wire logic                  timerClearReq,    // Timer clear request
   input wire logic                  timerHold,        // Timer hold
   input wire logic                  sleepMode,        // Device asleep
   input wire logic                  converterEnable,  // Converter enabled
   input wire logic                  specialTrigger,   // Trigger pulse
   input wire logic                  conversionStart,  // Conversion pulse
   input wire logic                  unitRequestFlag,  // Request flag
   input wire tccu_pkg::tccu_tbsel_t timebaseSel       // Timebase code
);
   import tccu_pkg::*;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   // A taken request completes after one wait cycle
   a_one_wait: assert property ((read || write) && waitrequest |=> !waitrequest)
      else $error("request not answered after one wait cycle");
   // An idle bus keeps the slave stalled
   a_idle_wait: assert property (!read && !write |=> waitrequest)
      else $error("waitrequest low without request");
   // Read data is zero outside the answer cycle
   a_rdata_idle: assert property (waitrequest |-> readdata == 32'h0)
      else $error("read data not cleared");
   // Only a status write may drop the flag
   a_flag_sticky: assert property (
      unitRequestFlag && !(write && address == `TCCU_OFS_STATUS) |=> unitRequestFlag)
      else $error("request flag cleared by hardware");
   // Trigger is a single-cycle pulse
   a_trig_pulse: assert property (specialTrigger |=> !specialTrigger)
      else $error("special trigger longer than one cycle");
   // Trigger requests the timer clear and starts a conversion when enabled
   a_trig_clear: assert property (
      specialTrigger |-> timerClearReq && conversionStart == $past(converterEnable))
      else $error("trigger without clear or conversion");
   // Clear request falls after the timer tick that used it
   a_clear_tick: assert property (timerClearReq && timerTick |=> !timerClearReq)
      else $error("clear request outlived its tick");
   // Timer holds in sleep only with the instruction clock
   a_hold_sleep: assert property (
      1'b1 |=> timerHold == $past(sleepMode && !timerExtClock))
      else $error("timer hold wrong");
   // No compare trigger while asleep
   a_sleep_quiet: assert property (sleepMode && $past(sleepMode) |-> !specialTrigger)
      else $error("trigger during sleep");
   // Reserved timebase code never held
   a_tb_legal: assert property (timebaseSel != `TCCU_TIMEBASE_RSVD)
      else $error("reserved timebase code held");
endmodule : tccu_monitor

// ===== verif/tccu_timer_model.sv
/* Behavioural 16-bit timer beside the unit: one count per tick, a tick
   every fourth system clock. Assumes the unit's clear and hold requests. */
`timescale 1ns/10ps
module tccu_timer_model (
   input  wire logic             sys_clk,        // System clock
   input  wire logic             reset,          // Synchronous, active high
   input  wire logic             timerClearReq,  // Clear at the next tick
   input  wire logic             timerHold,      // Freeze the count
   output tccu_pkg::tccu_count_t timerCount,     // Count value
   output logic                  timerTick       // One-cycle tick marker
);
   import tccu_pkg::*;
   logic [1:0]  divQ;   // Quarter-rate divider
   tccu_count_t cntQ;   // Count register
   logic        tickQ;  // Tick register
   assign timerCount = cntQ;
   assign timerTick  = tickQ;
   // Instruction-clock ticks, none while held
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         divQ  <= 2'h0;
         tickQ <= 1'b0;
      end else begin
         divQ  <= divQ + 2'h1;
         tickQ <= (divQ == 2'h3) && !timerHold;
      end
   end
   // Count advances, or clears on a requested tick
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         cntQ <= 16'h0000;
      end else if (tickQ) begin
         cntQ <= timerClearReq ? 16'h0000 : cntQ + 16'h0001;
      end
   end
endmodule : tccu_timer_model

// ===== verif/test_timer_capture_compare_unit.sv
/* Self-checking bench of the capture/compare unit.
   Assumes the timer model and the port checker of this folder. */
`timescale 1ns/10ps
`include "tccu_map.svh"
module test_timer_capture_compare_unit;
   import tccu_pkg::*;
   typedef struct {tccu_mode_t m; int p; logic f, pin, oeN;} tccu_row_t;
   logic        sys_clk = 1'b0, reset = 1'b1, read = 1'b0, write = 1'b0, convEn = 1'b1;
   logic        pinQ = 1'b0, portLatch = 1'b0, pinDir = 1'b1, sleepMode = 1'b0, extClk = 1'b0;
   logic [4:0]  address = 5'h00;
   logic [3:0]  byteenable = 4'hf;
   logic [31:0] writedata = 32'h0, readdata, q;
   logic        waitrequest, timerTick, clrReq, hold, pinOut, oeN, trig, conv, flag;
   tccu_count_t timerCount, cap, riseCnt, fallCnt;
   tccu_tbsel_t tbSel;
   int          errors = 0, testsRun = 0, convs = 0, n;
   // Mode, pin pulses, then expected flag, pin and enable
   tccu_row_t rows[11] = '{'{TCCU_CAP_FALL, 1, 1, 0, 1}, '{TCCU_CAP_RISE, 1, 1, 0, 1},
      '{TCCU_CAP_RISE4, 3, 0, 0, 1}, '{TCCU_CAP_RISE4, 4, 1, 0, 1},
      '{TCCU_CAP_RISE16, 15, 0, 0, 1}, '{TCCU_CAP_RISE16, 16, 1, 0, 1},
      '{TCCU_CMP_TOGGLE, 0, 1, 1, 0}, '{TCCU_CMP_CLEAR, 0, 1, 0, 0},
      '{TCCU_CMP_SOFT, 0, 1, 0, 1}, '{TCCU_CMP_TRIG, 0, 1, 0, 1}, '{TCCU_CMP_SET, 0, 1, 1, 0}};
   tccu_top tccu_top_i (.sys_clk, .reset, .address, .read, .write, .writedata, .byteenable,
      .readdata, .waitrequest, .timerCount, .timerTick, .timerExtClock(extClk),
      .timerClearReq(clrReq), .timerHold(hold), .unitPinIn(oeN ? pinQ : pinOut), .portLatch,
      .pinDirection(pinDir), .unitPinOut(pinOut), .unitPinOeN(oeN), .sleepMode,
      .converterEnable(convEn), .specialTrigger(trig), .conversionStart(conv),
      .unitRequestFlag(flag), .timebaseSel(tbSel));
   tccu_timer_model tccu_timer_model_i (.sys_clk, .reset, .timerClearReq(clrReq),
      .timerHold(hold), .timerCount, .timerTick);
   // 200 MHz clock
   initial begin
      forever #2.5 sys_clk = ~sys_clk;
   end
   // Count conversion starts
   always @(posedge sys_clk) begin
      if (conv === 1'b1) convs++;
   end
   // One bus transfer; read data lands in q
   task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
      int k;
      k = 0;
      write <= wr;
      read <= !wr;
      address <= a;
      writedata <= {24'h0, d};
      do begin
         @(posedge sys_clk);
         k++;
      end while (waitrequest !== 1'b0 && k < 50);
      if (k >= 50) errors++;
      q = readdata;
      write <= 1'b0;
      read <= 1'b0;
      @(posedge sys_clk);
   endtask : bus
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      testsRun++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   // Wait for the edge that carries a timer tick
   task automatic tick();
      do @(posedge sys_clk); while (timerTick !== 1'b1);
   endtask : tick
   // Whole pin pulses; remember the count at each edge
   task automatic pulse(input int cnt);
      repeat (cnt) begin
         pinQ <= 1'b1;
         tick();
         riseCnt = timerCount;
         pinQ <= 1'b0;
         tick();
         fallCnt = timerCount;
      end
   endtask : pulse
   // Unit off, holding ahead of the timer, new mode, flag cleared
   task automatic setup(input tccu_mode_t m);
      cap = timerCount + 16'h0040;
      bus(1'b1, `TCCU_OFS_CONTROL, 8'h00);
      bus(1'b1, `TCCU_OFS_HOLD_LOW, cap[7:0]);
      bus(1'b1, `TCCU_OFS_HOLD_HIGH, cap[15:8]);
      bus(1'b1, `TCCU_OFS_CONTROL, {4'h0, m});
      bus(1'b1, `TCCU_OFS_STATUS, 8'h01);
   endtask : setup
   task automatic readHold(input tccu_count_t exp);
      logic [7:0] lo;
      bus(1'b0, `TCCU_OFS_HOLD_LOW, 8'h00);
      lo = q[7:0];
      bus(1'b0, `TCCU_OFS_HOLD_HIGH, 8'h00);
      check({16'h0, q[7:0], lo}, {16'h0, exp});
   endtask : readHold
   task automatic tally_and_finish();
      $display("errors %0d, comparisons %0d", errors, testsRun);
      if (errors == 0 && testsRun > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : tally_and_finish
   // Hang guard
   initial begin
      repeat (40000) @(posedge sys_clk);
      errors++;
      tally_and_finish();
   end
   // Main sequence
   initial begin
      repeat (16) @(posedge sys_clk);
      reset <= 1'b0;
      @(posedge sys_clk);
      // Reset values, unmapped place last
      for (int a = 0; a < 24; a += 4) begin
         bus(1'b0, a[4:0], 8'h00);
         check(q, 32'h0);
      end
      check(oeN, 1'b1);
      // Timebase: reserved code and missing byte lane ignored
      bus(1'b1, `TCCU_OFS_TIMEBASE, 8'h01);
      bus(1'b1, `TCCU_OFS_TIMEBASE, 8'h03);
      byteenable <= 4'he;
      bus(1'b1, `TCCU_OFS_TIMEBASE, 8'h02);
      byteenable <= 4'hf;
      bus(1'b0, `TCCU_OFS_TIMEBASE, 8'h00);
      check(q, 32'h1);
      check(tbSel, 2'h1);
      foreach (rows[i]) begin
         pinDir <= (rows[i].p > 0);
         setup(rows[i].m);
         if (rows[i].p > 0) begin
            pulse(rows[i].p);
            repeat (2) @(posedge sys_clk);
            check(flag, rows[i].f);
            if (rows[i].f) readHold(rows[i].m == TCCU_CAP_FALL ? fallCnt : riseCnt);
         end else begin
            n = 0;
            while (flag !== 1'b1 && n < 600) begin
               @(posedge sys_clk);
               n++;
            end
            repeat (10) @(posedge sys_clk);
            check(flag, 1'b1);
            check(oeN, rows[i].oeN);
            if (!rows[i].oeN) check(pinOut, rows[i].pin);
            if (rows[i].m == TCCU_CMP_TRIG) check(timerCount < 16'h0004, 1'b1);
         end
      end
      check(convs, 1);
      // Control zero drops the set compare latch
      bus(1'b1, `TCCU_OFS_CONTROL, 8'h00);
      check(pinOut, 1'b0);
      @(posedge sys_clk);
      check(oeN, 1'b1);
      // Trigger with the converter off clears the timer, starts nothing
      convEn <= 1'b0;
      setup(TCCU_CMP_TRIG);
      repeat (400) @(posedge sys_clk);
      check(flag, 1'b1);
      check(timerCount < 16'h0040, 1'b1);
      check(convs, 1);
      // Second capture overwrites the unread one
      pinDir <= 1'b1;
      setup(TCCU_CAP_RISE);
      pulse(2);
      readHold(riseCnt);
      // Port latch change on an output pin captures
      pinDir <= 1'b0;
      setup(TCCU_CAP_RISE);
      portLatch <= 1'b1;
      tick();
      tick();
      repeat (2) @(posedge sys_clk);
      check(flag, 1'b1);
      // Sleep freezes the timer unless externally clocked
      sleepMode <= 1'b1;
      repeat (6) @(posedge sys_clk);
      cap = timerCount;
      repeat (20) @(posedge sys_clk);
      check(timerCount, cap);
      extClk <= 1'b1;
      repeat (20) @(posedge sys_clk);
      check(timerCount !== cap, 1'b1);
      sleepMode <= 1'b0;
      // Reset in mid-run clears flag, timebase and control
      reset <= 1'b1;
      repeat (2) @(posedge sys_clk);
      reset <= 1'b0;
      @(posedge sys_clk);
      check(flag, 1'b0);
      check(tbSel, 2'h0);
      bus(1'b0, `TCCU_OFS_CONTROL, 8'h00);
      check(q, 32'h0);
      tally_and_finish();
   end
endmodule : test_timer_capture_compare_unit

bind tccu_top tccu_monitor tccu_monitor_i (.sys_clk, .reset, .address, .read, .write,
   .readdata, .waitrequest, .timerTick, .timerExtClock, .timerClearReq, .timerHold,
   .sleepMode, .converterEnable, .specialTrigger, .conversionStart, .unitRequestFlag,
   .timebaseSel);
